// [core/mawm_pkg.sv]
package mawm_pkg;

    // Clock and time base
    localparam int          CLK_HZ          = 100_000_000;          // System clock rate
    localparam int          CLK_PERIOD_NS   = 10;                   // Period at that rate
    localparam int          MS_PER_S        = 1000;                 // Unit conversion
    localparam int          CYCLES_PER_MS   = CLK_HZ / MS_PER_S;    // Default millisecond prescale
    localparam int          LOCK_WARN_S     = 1;                    // Lock warning time in seconds
    localparam logic [15:0] LOCK_WARN_MS    = 16'(LOCK_WARN_S * MS_PER_S);
    localparam logic [1:0]  POR_SETTLE      = 2'h3;                 // Cycles until synced pins are valid

    // Speed thresholds in r/min
    localparam logic [11:0] OVERSPEED_RPM   = 12'd2300;
    localparam logic [11:0] BRAKE_RPM       = 12'd2100;

    // History depths
    localparam int          HIST_DEPTH      = 9;
    localparam logic [3:0]  HIST_LAST       = 4'(HIST_DEPTH - 1);
    localparam int          WHIST_DEPTH     = 4;

    // Register offsets
    localparam logic [7:0]  ADDR_CONFIG     = 8'h00;
    localparam logic [7:0]  ADDR_COMMAND    = 8'h04;
    localparam logic [7:0]  ADDR_STATUS     = 8'h08;
    localparam logic [7:0]  ADDR_HIST_SEL   = 8'h0C;
    localparam logic [7:0]  ADDR_HIST_DATA  = 8'h10;
    localparam logic [7:0]  ADDR_WARN_HIST  = 8'h14;

    // Config fields
    localparam int          CFG_LOCK_LSB    = 0;
    localparam int          CFG_PPE_BIT     = 16;
    localparam int          CFG_EXT_BIT     = 17;
    localparam int          CFG_CAU_BIT     = 18;
    // Command fields
    localparam int          CMD_PANEL_BIT   = 0;
    localparam int          CMD_HCLR_BIT    = 1;
    localparam int          CMD_ASSIGN_BIT  = 2;
    localparam int          CMD_TERM_LSB    = 3;
    localparam int          CMD_INCH_BIT    = 6;
    localparam int          CMD_TEXIT_BIT   = 7;
    // Status fields
    localparam int          STAT_CODE_LSB   = 0;
    localparam int          STAT_ALM_BIT    = 8;
    localparam int          STAT_LWRN_BIT   = 9;
    localparam int          STAT_OPERR_BIT  = 10;
    localparam int          STAT_CLR_BIT    = 11;
    localparam int          STAT_BRAKE_BIT  = 12;

    // Reset values
    localparam logic [15:0] LOCK_TIME_RST   = 16'h0BB8;
    localparam logic        PPE_RST         = 1'b1;
    localparam logic        EXT_RST         = 1'b0;
    localparam logic        CAU_RST         = 1'b0;

    // Alarm and warning codes
    localparam logic [7:0]  ALM_NONE        = 8'h00;
    localparam logic [7:0]  ALM_OVERHEAT    = 8'h21;
    localparam logic [7:0]  ALM_LOCK        = 8'h30;
    localparam logic [7:0]  ALM_OVERSPEED   = 8'h31;
    localparam logic [7:0]  ALM_NVM         = 8'h41;
    localparam logic [7:0]  ALM_POWERON     = 8'h45;
    localparam logic [7:0]  ALM_EXTSTOP     = 8'h5E;
    localparam logic [3:0]  WRN_LOCK        = 4'h1;
    localparam logic [3:0]  WRN_OPERR       = 4'h2;

    // Top level phase, Gray along settle, run, alarm
    typedef enum logic [1:0] {
        MAWM_SETTLE = 2'b00,
        MAWM_RUN    = 2'b01,
        MAWM_ALARM  = 2'b11
    } mawm_phase_t;

    // Motor command toward the power stage
    typedef enum logic [2:0] {
        MAWM_COAST   = 3'b000,
        MAWM_DECEL   = 3'b001,
        MAWM_RUN_FWD = 3'b011,
        MAWM_RUN_BWD = 3'b010,
        MAWM_HALT    = 3'b110
    } mawm_motor_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mawm_bus_req_t;

    typedef struct packed {
        logic        dirForwardIn;
        logic        dirBackwardIn;
        logic        alarmResetIn;
        logic        externalStopIn;
        logic        thermalOpenIn;
        logic        shaftLockedIn;
        logic        nvmFaultIn;
        logic [5:0]  terminalIn;
    } mawm_pins_t;

    typedef struct packed {
        logic        alarmOut;
        logic        alarmLed;
        logic [7:0]  displayCode;
        logic        displayBlink;
        logic        cautionOut;
    } mawm_panel_t;

    typedef struct packed {
        mawm_motor_t motorCmd;
        logic        brake;
    } mawm_drive_t;

    localparam mawm_panel_t PANEL_RST = '{alarmOut: 1'b1, alarmLed: 1'b0, displayCode: ALM_NONE,
                                          displayBlink: 1'b0, cautionOut: 1'b0};
    localparam mawm_drive_t DRIVE_RST = '{motorCmd: MAWM_COAST, brake: 1'b0};

endpackage : mawm_pkg

// [core/mawm_pin_sync.sv]
`timescale 1ns/100ps

// Two stage synchroniser for every asynchronous pin of the block
module mawm_pin_sync (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire mawm_pkg::mawm_pins_t pinsRaw,
    output      mawm_pkg::mawm_pins_t pinsSync
);
    import mawm_pkg::*;

    mawm_pins_t stage1;     // Metastable stage, read only by stage two
    mawm_pins_t stage2;     // Settled copy

    // Both stages reset to zero; the main block masks the first cycles anyway
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= pinsRaw;
            stage2 <= stage1;
        end
    end

    assign pinsSync = stage2;

endmodule : mawm_pin_sync

// [core/motor_alarm_warning_manager.sv]
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps

//Contract
// - Any alarm removes drive, motor coasts
// - Alarm: output off, red lamp, code shown
// - Thermal protector open raises overheat alarm
// - Lock longer than set time raises alarm
// - Speed above 2300 r/min raises overspeed
// - Above 2100 r/min apply braking current
// - Direction at power-up alarms, clears when released
// - Power-up check disableable, enabled by default
// - External stop inactive alarms when assigned
// - Storage error alarm, not reset-input clearable
// - Reset input acts on rising edge only
// - Reset input ignored while direction active
// - Reset by edge, panel or power
// - Keep nine alarms newest first, drop oldest
// - Clear history on command, blink meanwhile
// - Caution output on any active warning
// - Caution output unassigned after reset
// - Warning history volatile, lost on power
// - Lock one second warns, keep running
// - Direction assigned to active terminal: warn, stop
// - Direction active at test exit: warn, stop
// - Warning output drops once condition released
// - Alarm output normally closed
// - Directions run motor, release decelerates
module motor_alarm_warning_manager #(
    parameter int CYCLES_PER_MS_P = mawm_pkg::CYCLES_PER_MS
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire mawm_pkg::mawm_bus_req_t busReq,
    output      logic [31:0]            busRdata,
    input  wire mawm_pkg::mawm_pins_t   pinsRaw,
    input  wire logic [11:0]            speedRpm,
    output      mawm_pkg::mawm_panel_t  panel,
    output      mawm_pkg::mawm_drive_t  drive
);
    import mawm_pkg::*;

    // Registered state of the block except the alarm history and pin synchroniser
    typedef struct packed {
        mawm_phase_t phase;          // Settle, run or alarm
        logic [1:0]  settle;         // Power-up settle counter
        logic [15:0] lockTime;       // Lock alarm time in ms
        logic        ppe;            // Power-up prevention enable
        logic        extAsg;         // External stop assigned
        logic        cauAsg;         // Caution output assigned
        logic [3:0]  histSel;        // History read index
        logic [7:0]  alarmCode;      // Latched alarm code
        logic        resetPrev;      // Reset input last cycle
        logic [16:0] msCount;        // Millisecond prescaler
        logic [15:0] lockMs;         // Locked duration in ms
        logic        lockWarn;       // Lock warning active
        logic        opError;        // Operation error warning
        logic        inchDone;       // Manual inch run happened
        logic        clearing;       // History clear in progress
        logic [3:0]  clearIdx;       // Entry being cleared
        logic [15:0] warnHist;       // Four codes, newest low
        mawm_panel_t panel;          // Registered panel outputs
        mawm_drive_t drive;          // Registered drive outputs
        logic [31:0] rdata;          // Read data, one cycle
    } mawm_state_t;

    localparam mawm_state_t STATE_RST = '{
        phase: MAWM_SETTLE, settle: 2'h0, lockTime: LOCK_TIME_RST, ppe: PPE_RST,
        extAsg: EXT_RST, cauAsg: CAU_RST, histSel: 4'h0, alarmCode: ALM_NONE,
        resetPrev: 1'b0, msCount: 17'h00000, lockMs: 16'h0000, lockWarn: 1'b0,
        opError: 1'b0, inchDone: 1'b0, clearing: 1'b0, clearIdx: 4'h0,
        warnHist: 16'h0000, panel: PANEL_RST, drive: DRIVE_RST, rdata: 32'h00000000
    };

    mawm_state_t q;                          // Current state
    mawm_state_t next_q;                     // Next state
    mawm_pins_t  pins;                       // Synchronised pins
    logic [7:0]  alarmHist [HIST_DEPTH];     // Alarm history, newest at 0
    logic        histPush;                   // Shift in a new alarm
    logic [7:0]  histPushCode;               // Code being shifted in
    logic        histWipe;                   // Zero one entry

    // Fixed-priority choice among live fault conditions
    function automatic logic [7:0] alarm_pick(
        input logic nvmBad,
        input logic hot,
        input logic fast,
        input logic locked,
        input logic extStop
    );
        logic [7:0] code;
        code = ALM_NONE;
        if (nvmBad) begin
            code = ALM_NVM;
        end else if (hot) begin
            code = ALM_OVERHEAT;
        end else if (fast) begin
            code = ALM_OVERSPEED;
        end else if (locked) begin
            code = ALM_LOCK;
        end else if (extStop) begin
            code = ALM_EXTSTOP;
        end
        return code;
    endfunction : alarm_pick

    // Shift a warning code into the volatile record
    function automatic logic [15:0] warn_push(
        input logic [15:0] hist,
        input logic [3:0]  code
    );
        return {hist[11:0], code};
    endfunction : warn_push

    // Pins arrive from outside, so each passes two flops first
    mawm_pin_sync u_sync (
        .clock    (clock),
        .rst      (rst),
        .pinsRaw  (pinsRaw),
        .pinsSync (pins)
    );

    // Next-state logic for the whole block
    always_comb begin
        logic       dirAny;
        logic       msTick;
        logic       lockAlarm;
        logic       overSpeed;
        logic [7:0] faultCode;
        logic       cmdPanel;
        logic       cmdClear;
        logic       cmdAssign;
        logic [2:0] cmdTerm;
        logic       cmdInch;
        logic       cmdExit;
        logic       resetEdge;
        logic       doClear;
        logic [31:0] rd;
        dirAny    = pins.dirForwardIn | pins.dirBackwardIn;
        msTick    = 1'b0;
        lockAlarm = 1'b0;
        overSpeed = 1'b0;
        faultCode = ALM_NONE;
        cmdPanel  = 1'b0;
        cmdClear  = 1'b0;
        cmdAssign = 1'b0;
        cmdTerm   = 3'h0;
        cmdInch   = 1'b0;
        cmdExit   = 1'b0;
        resetEdge = 1'b0;
        doClear   = 1'b0;
        rd        = 32'h00000000;
        next_q    = q;
        histPush     = 1'b0;
        histPushCode = ALM_NONE;
        histWipe     = 1'b0;

        // Register writes
        if (busReq.wr) begin
            case (busReq.addr)
                ADDR_CONFIG: begin
                    next_q.lockTime = busReq.wdata[CFG_LOCK_LSB +: 16];
                    next_q.ppe      = busReq.wdata[CFG_PPE_BIT];
                    next_q.extAsg   = busReq.wdata[CFG_EXT_BIT];
                    next_q.cauAsg   = busReq.wdata[CFG_CAU_BIT];
                end
                ADDR_COMMAND: begin
                    // Self-clearing command bits, nothing is stored
                    cmdPanel  = busReq.wdata[CMD_PANEL_BIT];
                    cmdClear  = busReq.wdata[CMD_HCLR_BIT];
                    cmdAssign = busReq.wdata[CMD_ASSIGN_BIT];
                    cmdTerm   = busReq.wdata[CMD_TERM_LSB +: 3];
                    cmdInch   = busReq.wdata[CMD_INCH_BIT];
                    cmdExit   = busReq.wdata[CMD_TEXIT_BIT];
                end
                ADDR_HIST_SEL: begin
                    next_q.histSel = busReq.wdata[3:0];
                end
                default: begin
                    // Unmapped or read-only, write dropped
                end
            endcase
        end

        // Millisecond time base for the lock timers
        if (q.msCount == 17'(CYCLES_PER_MS_P - 1)) begin
            next_q.msCount = 17'h00000;
            msTick         = 1'b1;
        end else begin
            next_q.msCount = q.msCount + 17'h00001;
        end

        // Locked duration, saturating so a long stall cannot wrap to zero
        if (!pins.shaftLockedIn) begin
            next_q.lockMs = 16'h0000;
        end else if (msTick && q.lockMs != 16'hFFFF) begin
            next_q.lockMs = q.lockMs + 16'h0001;
        end
        next_q.lockWarn = pins.shaftLockedIn && (q.lockMs >= LOCK_WARN_MS);
        lockAlarm       = pins.shaftLockedIn && (q.lockMs > q.lockTime);
        overSpeed       = speedRpm > OVERSPEED_RPM;

        // Manual inch run bookkeeping for the test mode exit check
        if (cmdInch) begin
            next_q.inchDone = 1'b1;
        end
        if (cmdExit) begin
            next_q.inchDone = 1'b0;
        end

        // Operation error: released directions clear it, a new cause wins
        if (!dirAny) begin
            next_q.opError = 1'b0;
        end
        if (cmdAssign && pins.terminalIn[cmdTerm]) begin
            next_q.opError = 1'b1;
        end
        if (cmdExit && q.inchDone && dirAny) begin
            next_q.opError = 1'b1;
        end

        // Volatile warning record on each rising warning
        if (next_q.lockWarn && !q.lockWarn) begin
            next_q.warnHist = warn_push(next_q.warnHist, WRN_LOCK);
        end
        if (next_q.opError && !q.opError) begin
            next_q.warnHist = warn_push(next_q.warnHist, WRN_OPERR);
        end

        // Faults seen while running, one code per type
        faultCode = alarm_pick(pins.nvmFaultIn, pins.thermalOpenIn, overSpeed,
                               lockAlarm, q.extAsg && !pins.externalStopIn);

        // Reset input acts on its off-to-on edge, never with a direction on
        resetEdge = pins.alarmResetIn && !q.resetPrev && !dirAny;
        next_q.resetPrev = pins.alarmResetIn;

        // Phase machine
        case (q.phase)
            MAWM_SETTLE: begin
                // Wait for the synchronisers before judging the pins
                if (q.settle != POR_SETTLE) begin
                    next_q.settle = q.settle + 2'h1;
                end else if (q.ppe && dirAny) begin
                    next_q.phase     = MAWM_ALARM;
                    next_q.alarmCode = ALM_POWERON;
                    histPush         = 1'b1;
                    histPushCode     = ALM_POWERON;
                end else begin
                    next_q.phase = MAWM_RUN;
                end
            end
            MAWM_RUN: begin
                if (faultCode != ALM_NONE) begin
                    next_q.phase     = MAWM_ALARM;
                    next_q.alarmCode = faultCode;
                    histPush         = 1'b1;
                    histPushCode     = faultCode;
                end
            end
            MAWM_ALARM: begin
                // Storage error survives both edge and panel reset
                if (q.alarmCode == ALM_POWERON) begin
                    doClear = !dirAny;
                end else if (q.alarmCode != ALM_NVM) begin
                    doClear = resetEdge || cmdPanel;
                end
                if (doClear) begin
                    next_q.phase     = MAWM_RUN;
                    next_q.alarmCode = ALM_NONE;
                end
            end
            default: begin
                next_q.phase = MAWM_SETTLE;
            end
        endcase

        // History clear walks all entries, one per cycle
        if (q.clearing) begin
            histWipe = 1'b1;
            if (q.clearIdx == HIST_LAST) begin
                next_q.clearing = 1'b0;
            end else begin
                next_q.clearIdx = q.clearIdx + 4'h1;
            end
        end else if (cmdClear) begin
            next_q.clearing = 1'b1;
            next_q.clearIdx = 4'h0;
        end

        // Panel outputs follow the next phase so they switch with the drive
        next_q.panel.alarmOut     = next_q.phase != MAWM_ALARM;
        next_q.panel.alarmLed     = next_q.phase == MAWM_ALARM;
        next_q.panel.displayCode  = next_q.alarmCode;
        next_q.panel.displayBlink = next_q.clearing;
        next_q.panel.cautionOut   = next_q.cauAsg &&
                                    (next_q.lockWarn || next_q.opError);

        // Drive: coast in alarm, lock warning alone keeps running
        if (next_q.phase != MAWM_RUN) begin
            next_q.drive.motorCmd = MAWM_COAST;
            next_q.drive.brake    = 1'b0;
        end else begin
            next_q.drive.brake = speedRpm > BRAKE_RPM;
            if (next_q.opError) begin
                next_q.drive.motorCmd = MAWM_HALT;
            end else if (pins.dirForwardIn && pins.dirBackwardIn) begin
                next_q.drive.motorCmd = MAWM_HALT;
            end else if (pins.dirForwardIn) begin
                next_q.drive.motorCmd = MAWM_RUN_FWD;
            end else if (pins.dirBackwardIn) begin
                next_q.drive.motorCmd = MAWM_RUN_BWD;
            end else begin
                next_q.drive.motorCmd = MAWM_DECEL;
            end
        end

        // Read data stands for exactly the cycle after the strobe
        if (busReq.rd) begin
            case (busReq.addr)
                ADDR_CONFIG: begin
                    rd[CFG_LOCK_LSB +: 16] = q.lockTime;
                    rd[CFG_PPE_BIT]        = q.ppe;
                    rd[CFG_EXT_BIT]        = q.extAsg;
                    rd[CFG_CAU_BIT]        = q.cauAsg;
                end
                ADDR_STATUS: begin
                    rd[STAT_CODE_LSB +: 8] = q.alarmCode;
                    rd[STAT_ALM_BIT]       = q.phase == MAWM_ALARM;
                    rd[STAT_LWRN_BIT]      = q.lockWarn;
                    rd[STAT_OPERR_BIT]     = q.opError;
                    rd[STAT_CLR_BIT]       = q.clearing;
                    rd[STAT_BRAKE_BIT]     = q.drive.brake;
                end
                ADDR_HIST_SEL: begin
                    rd[3:0] = q.histSel;
                end
                ADDR_HIST_DATA: begin
                    // Indexes past the last entry read as empty
                    if (q.histSel <= HIST_LAST) begin
                        rd[7:0] = alarmHist[q.histSel];
                    end
                end
                ADDR_WARN_HIST: begin
                    rd[15:0] = q.warnHist;
                end
                default: begin
                    // Command and unmapped read as zero
                end
            endcase
        end
        next_q.rdata = rd;
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= STATE_RST;
        end else begin
            q <= next_q;
        end
    end

    // Alarm history has no reset: it stands in for nonvolatile storage
    always_ff @(posedge clock) begin
        if (histWipe) begin
            alarmHist[q.clearIdx] <= ALM_NONE;
        end else if (histPush) begin
            for (int i = HIST_DEPTH - 1; i > 0; i--) begin
                alarmHist[i] <= alarmHist[i - 1];
            end
            alarmHist[0] <= histPushCode;
        end
    end

    assign busRdata = q.rdata;
    assign panel    = q.panel;
    assign drive    = q.drive;

endmodule : motor_alarm_warning_manager

// [bench/mawm_properties.sv]
`timescale 1ns/100ps
// Port-level checker
module mawm_properties (
    input wire logic                    clock,
    input wire logic                    rst,
    input wire mawm_pkg::mawm_bus_req_t busReq,
    input wire mawm_pkg::mawm_pins_t    pinsRaw,
    input wire logic [11:0]             speedRpm,
    input wire mawm_pkg::mawm_panel_t   panel,
    input wire mawm_pkg::mawm_drive_t   drive
);
    import mawm_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Blink runs nine cycles, then stops
    sequence s_blink_run;
        panel.displayBlink[*8] ##1 !panel.displayBlink;
    endsequence
    a_alarm_coast: assert property (panel.alarmLed |-> drive.motorCmd == MAWM_COAST)
        else $error("drive kept in alarm");
    a_alarm_pair: assert property (panel.alarmOut != panel.alarmLed)
        else $error("alarm output and lamp disagree");
    a_brake_speed: assert property (drive.brake |-> $past(speedRpm) > BRAKE_RPM)
        else $error("brake below limit");
    a_heat_raise: assert property (pinsRaw.thermalOpenIn[*4] |-> ##[0:10] panel.alarmLed)
        else $error("no overheat alarm");
    a_speed_raise: assert property (speedRpm > OVERSPEED_RPM |-> ##[1:10] panel.alarmLed)
        else $error("no overspeed alarm");
    a_store_sticky: assert property (panel.alarmLed && panel.displayCode == ALM_NVM |=> panel.alarmLed)
        else $error("storage alarm cleared");
    // Apart from the power-up alarm, only a bus write or a reset pin edge may clear a latched alarm
    a_clear_cause: assert property ($fell(panel.alarmLed) &&
        $past(panel.displayCode) != ALM_POWERON |-> busReq.wr || $past(busReq.wr) ||
        $past(pinsRaw.alarmResetIn, 2) || $past(pinsRaw.alarmResetIn, 3))
        else $error("alarm cleared without reset");
    a_blink_len: assert property ($rose(panel.displayBlink) |=> s_blink_run)
        else $error("blink length wrong");
endmodule : mawm_properties

bind motor_alarm_warning_manager mawm_properties u_mawm_properties (.clock(clock), .rst(rst), .busReq(busReq),
    .pinsRaw(pinsRaw), .speedRpm(speedRpm), .panel(panel), .drive(drive));

// [bench/mawm_motor_model.sv]
`timescale 1ns/100ps
// Motor with an overhauling load
module mawm_motor_model (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire mawm_pkg::mawm_drive_t drive,
    input  wire logic [11:0]           loadRpm,
    output      logic [11:0]           speedRpm
);
    import mawm_pkg::*;
    logic [11:0] goal; // Speed the load pulls toward
    // Turns only under a direction command, else runs down
    assign goal = (drive.motorCmd inside {MAWM_RUN_FWD, MAWM_RUN_BWD}) ? loadRpm : 12'h000;
    // Brake only slows the climb, the load still wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) speedRpm <= 12'h000;
        else if (speedRpm < goal) speedRpm <= speedRpm + (drive.brake ? 12'h014 : 12'h064);
        else if (speedRpm > goal) speedRpm <= (speedRpm > 12'h064) ? speedRpm - 12'h064 : 12'h000;
    end
endmodule : mawm_motor_model

// [bench/motor_alarm_warning_manager_tb_top.sv]
`timescale 1ns/100ps
module motor_alarm_warning_manager_tb_top;
    import mawm_pkg::*;
    logic          clock, rst, sawBrake;
    mawm_bus_req_t busReq;
    logic [31:0]   busRdata, rdv;
    mawm_pins_t    pinsRaw;
    logic [11:0]   speedRpm, loadRpm;
    mawm_panel_t   panel;
    mawm_drive_t   drive;
    int            errorCnt, nTests, cyc;
    // Short millisecond so lock counts stay small
    motor_alarm_warning_manager #(.CYCLES_PER_MS_P(10)) u_motor_alarm_warning_manager (.clock(clock), .rst(rst),
        .busReq(busReq), .busRdata(busRdata), .pinsRaw(pinsRaw), .speedRpm(speedRpm), .panel(panel), .drive(drive));
    mawm_motor_model u_mawm_motor_model (.clock(clock), .rst(rst), .drive(drive), .loadRpm(loadRpm),
        .speedRpm(speedRpm));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(posedge clock);
    endtask : step
    // Single-cycle bus strobes
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        busReq.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clock);
        busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        busReq.rd <= 1'b0;
        #1 rdv = busRdata;
        @(posedge clock);
    endtask : rd
    task hist(input logic [3:0] n, input logic [7:0] c);
        wr(ADDR_HIST_SEL, {28'h0, n});
        rd(ADDR_HIST_DATA);
        chk(rdv, {24'h0, c});
    endtask : hist
    // Whole alarm face at once
    task alm(input logic [7:0] c);
        chk({19'h0, panel.alarmOut, panel.alarmLed, panel.displayCode, drive.motorCmd}, {19'h0, 2'b01, c, MAWM_COAST});
    endtask : alm
    task t_power;
        chk({30'h0, panel.alarmOut, panel.cautionOut}, 32'h2);
        rd(ADDR_CONFIG);
        chk(rdv, 32'h0001_0BB8);
        wr(ADDR_COMMAND, 32'h2);
        step(12);
        hist(4'h0, ALM_NONE);
        $display("power done");
    endtask : t_power
    task t_heat;
        pinsRaw.thermalOpenIn <= 1'b1;
        step(5);
        alm(ALM_OVERHEAT);
        pinsRaw <= '{dirForwardIn: 1'b1, alarmResetIn: 1'b1, default: 1'b0};
        step(5);
        alm(ALM_OVERHEAT);
        pinsRaw <= '0;
        step(5);
        pinsRaw.alarmResetIn <= 1'b1;
        step(5);
        chk({31'h0, panel.alarmLed}, 32'h0);
        hist(4'h0, ALM_OVERHEAT);
        $display("heat done");
    endtask : t_heat
    task t_speed;
        pinsRaw.dirForwardIn <= 1'b1;
        loadRpm <= 12'd2500;
        sawBrake = 1'b0;
        repeat (60) begin
            @(posedge clock);
            if (drive.brake === 1'b1) sawBrake = 1'b1;
        end
        chk({31'h0, sawBrake}, 32'h1);
        alm(ALM_OVERSPEED);
        loadRpm <= 12'h000;
        pinsRaw.dirForwardIn <= 1'b0;
        step(40);
        wr(ADDR_COMMAND, 32'h1);
        step(2);
        chk({31'h0, panel.alarmLed}, 32'h0);
        hist(4'h0, ALM_OVERSPEED);
        hist(4'h1, ALM_OVERHEAT);
        $display("speed done");
    endtask : t_speed
    // Lock warning after a second, then a shorter lock time trips the alarm
    task t_lock;
        wr(ADDR_CONFIG, 32'h0005_0BB8);
        pinsRaw.shaftLockedIn <= 1'b1;
        step(10020);
        chk({30'h0, panel.cautionOut, panel.alarmLed}, 32'h2);
        rd(ADDR_WARN_HIST);
        chk(rdv, 32'h1);
        wr(ADDR_CONFIG, 32'h0005_0400);
        step(300);
        alm(ALM_LOCK);
        pinsRaw.shaftLockedIn <= 1'b0;
        step(5);
        chk({31'h0, panel.cautionOut}, 32'h0);
        wr(ADDR_COMMAND, 32'h1);
        $display("lock done");
    endtask : t_lock
    task t_store;
        pinsRaw <= '{nvmFaultIn: 1'b1, default: 1'b0};
        step(5);
        pinsRaw.alarmResetIn <= 1'b1;
        wr(ADDR_COMMAND, 32'h1);
        step(5);
        alm(ALM_NVM);
        pinsRaw <= '{dirForwardIn: 1'b1, default: 1'b0};
        rst <= 1'b1;
        step(3);
        rst <= 1'b0;
        step(10);
        alm(ALM_POWERON);
        pinsRaw.dirForwardIn <= 1'b0;
        step(5);
        chk({31'h0, panel.alarmLed}, 32'h0);
        rd(ADDR_WARN_HIST);
        chk(rdv, 32'h0);
        $display("store done");
    endtask : t_store
    task end_sim;
        $display("tests %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            errorCnt++;
            end_sim();
        end
    end
    initial begin
        rst = 1'b1;
        busReq = '0;
        pinsRaw = '0;
        loadRpm = 12'h000;
        step(20);
        rst <= 1'b0;
        step(8);
        t_power();
        t_heat();
        t_speed();
        t_lock();
        t_store();
        end_sim();
    end
endmodule : motor_alarm_warning_manager_tb_top
